// ### design/pll_divider_config.sv
`timescale 1ns/1ps
`default_nettype none

module pll_divider_config (
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Serial write pins and power pins.
    input wire pll_cfg_pkg::serial_pins_t serial_pins,
    input wire logic chip_enable_pin,
    input wire logic auto_powerup,
    // Stored configuration.
    output pll_cfg_pkg::rf_divide_t rf_divide_q,
    output pll_cfg_pkg::rf_ref_t rf_ref_q,
    output pll_cfg_pkg::if_div_t if_div_q,
    // Derived RF divider values.
    output logic [5:0] rf_coarse_count_q,
    output logic [2:0] rf_mid_count_q,
    output logic [1:0] rf_fine_count_q,
    output logic [11:0] rf_divide_ratio_q,
    // Resolved power state.
    output pll_cfg_pkg::power_t power_q
);

    logic [pll_cfg_pkg::WORD_W-1:0] word;
    logic word_valid;
    logic ce_meta_q;
    logic ce_q;
    logic wake_q;
    logic wake_d;
    logic sel_div;
    logic sel_ref;
    logic sel_if;
    pll_cfg_pkg::rf_divide_t rf_divide_d;
    pll_cfg_pkg::rf_ref_t rf_ref_d;
    pll_cfg_pkg::if_div_t if_div_d;
    logic [5:0] coarse_d;
    logic [2:0] mid_d;
    logic [1:0] fine_d;
    logic [5:0] modulus;
    logic [11:0] ratio_d;
    pll_cfg_pkg::power_t power_d;

    serial_word_rx u_rx (
        .mclk(mclk),
        .resetn(resetn),
        .pins(serial_pins),
        .word_q(word),
        .word_valid_q(word_valid)
    );

    // The chip enable pin is asynchronous to mclk, so it passes two flops.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ce_meta_q <= 1'b0;
            ce_q <= 1'b0;
        end else begin
            ce_meta_q <= chip_enable_pin;
            ce_q <= ce_meta_q;
        end
    end

    // Register routing: bit 0 low selects the divide word; otherwise the select code in the low nibble.
    assign sel_div = word_valid && !word[0];
    assign sel_ref = word_valid && (word[pll_cfg_pkg::SEL_W-1:0] == pll_cfg_pkg::SEL_RF_REF);
    assign sel_if = word_valid && (word[pll_cfg_pkg::SEL_W-1:0] == pll_cfg_pkg::SEL_IF_DIV);

    // Field capture; values are kept exactly as written, legal or not.
    always_comb begin
        rf_divide_d = rf_divide_q;
        rf_ref_d = rf_ref_q;
        if_div_d = if_div_q;
        if (sel_div) begin
            rf_divide_d.main_divide = word[pll_cfg_pkg::RF_N_MSB:pll_cfg_pkg::RF_N_LSB];
            rf_divide_d.frac_num = word[pll_cfg_pkg::RF_FN_MSB:pll_cfg_pkg::RF_FN_LSB];
        end
        if (sel_ref) begin
            rf_ref_d.powerdown = word[pll_cfg_pkg::PD_BIT];
            rf_ref_d.prescaler_select = word[pll_cfg_pkg::PSEL_BIT];
            rf_ref_d.reference_divide = word[pll_cfg_pkg::RREF_MSB:pll_cfg_pkg::RREF_LSB];
            rf_ref_d.frac_den = word[pll_cfg_pkg::FD_MSB:pll_cfg_pkg::FD_LSB];
        end
        if (sel_if) begin
            if_div_d.powerdown = word[pll_cfg_pkg::PD_BIT];
            if_div_d.main_divide = word[pll_cfg_pkg::IF_N_MSB:pll_cfg_pkg::IF_N_LSB];
        end
        // A divide write with auto power-up set clears the IF powerdown bit.
        if (sel_div && auto_powerup) begin
            if_div_d.powerdown = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rf_divide_q <= pll_cfg_pkg::RST_RF_DIV;
            rf_ref_q <= pll_cfg_pkg::RST_RF_REF;
            if_div_q <= pll_cfg_pkg::RST_IF_DIV;
        end else begin
            rf_divide_q <= rf_divide_d;
            rf_ref_q <= rf_ref_d;
            if_div_q <= if_div_d;
        end
    end

    // Auto power-up request: raised by a divide write with auto_powerup set, dropped when
    // software rewrites the RF powerdown bit or turns auto_powerup off. A raise in the
    // same cycle as a drop wins, so the wake is never lost.
    always_comb begin
        wake_d = wake_q;
        if (sel_ref || !auto_powerup) begin
            wake_d = 1'b0;
        end
        if (sel_div && auto_powerup) begin
            wake_d = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_d;
        end
    end

    // Divider arithmetic from the stored main divide.
    always_comb begin
        modulus = rf_ref_q.prescaler_select ? pll_cfg_pkg::PRESC_LARGE : pll_cfg_pkg::PRESC_SMALL;
        coarse_d = rf_divide_q.main_divide[10:pll_cfg_pkg::COARSE_LSB];
        mid_d = rf_divide_q.main_divide[pll_cfg_pkg::COARSE_LSB-1:pll_cfg_pkg::MID_LSB];
        fine_d = rf_divide_q.main_divide[pll_cfg_pkg::MID_LSB-1:0];
        // Both factors are widened first so that the product cannot be cut to six bits.
        ratio_d = 12'(modulus) * 12'(coarse_d) + (12'(mid_d) << pll_cfg_pkg::MID_WEIGHT_SHIFT)
                  + 12'(fine_d);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rf_coarse_count_q <= 6'h00;
            rf_mid_count_q <= 3'h0;
            rf_fine_count_q <= 2'h0;
            rf_divide_ratio_q <= 12'h000;
        end else begin
            rf_coarse_count_q <= coarse_d;
            rf_mid_count_q <= mid_d;
            rf_fine_count_q <= fine_d;
            rf_divide_ratio_q <= ratio_d;
        end
    end

    // Power resolution; the chip enable pin dominates both synthesizers.
    always_comb begin
        power_d.rf_active = ce_q && (wake_q || !rf_ref_q.powerdown);
        power_d.rf_cp_hiz = !power_d.rf_active;
        power_d.if_active = ce_q && !if_div_q.powerdown;
        power_d.if_cp_hiz = !power_d.if_active;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            power_q <= pll_cfg_pkg::RST_POWER;
        end else begin
            power_q <= power_d;
        end
    end

    // Checks on routing, arithmetic and power precedence.
    a_div_word_load: assert property (@(posedge mclk) disable iff (!resetn)
        word_valid && !word[0] |=> rf_divide_q.main_divide == $past(word[23:13]))
        else $error("divide word not stored");
    a_ref_word_load: assert property (@(posedge mclk) disable iff (!resetn)
        sel_ref |=> rf_ref_q.reference_divide == $past(word[21:16]) && rf_ref_q.powerdown == $past(word[23]))
        else $error("reference word not stored");
    a_if_word_load: assert property (@(posedge mclk) disable iff (!resetn)
        sel_if && !auto_powerup |=> if_div_q == $past(word[23:4]))
        else $error("IF word not stored");
    a_ratio_formula: assert property (@(posedge mclk) disable iff (!resetn)
        ##1 rf_divide_ratio_q == 12'($past(rf_ref_q.prescaler_select) ? 32 : 16) * 12'($past(rf_divide_q.main_divide[10:5]))
            + 12'(4 * $past(rf_divide_q.main_divide[4:2])) + 12'($past(rf_divide_q.main_divide[1:0])))
        else $error("RF divide ratio wrong");
    // A prescaler flip over a steady divide moves the ratio by sixteen times the coarse count.
    a_presc_modulus: assert property (@(posedge mclk) disable iff (!resetn)
        $changed(rf_ref_q.prescaler_select) && $stable(rf_divide_q.main_divide)
        |=> rf_divide_ratio_q == ($past(rf_ref_q.prescaler_select)
            ? $past(rf_divide_ratio_q) + 12'(16 * $past(rf_divide_q.main_divide[10:5]))
            : $past(rf_divide_ratio_q) - 12'(16 * $past(rf_divide_q.main_divide[10:5]))))
        else $error("prescaler modulus wrong");
    a_ce_forces_down: assert property (@(posedge mclk) disable iff (!resetn)
        !ce_q |=> !power_q.rf_active && power_q.rf_cp_hiz && !power_q.if_active)
        else $error("chip enable low did not power down");
    a_wake_beats_pd: assert property (@(posedge mclk) disable iff (!resetn)
        sel_div && auto_powerup ##1 ce_q && !sel_ref && auto_powerup |=> power_q.rf_active)
        else $error("auto power-up ignored");
    a_rf_powerdown_obeyed: assert property (@(posedge mclk) disable iff (!resetn)
        ce_q && !wake_q && rf_ref_q.powerdown |=> !power_q.rf_active && power_q.rf_cp_hiz)
        else $error("RF powerdown bit ignored");
    a_if_powerdown_clear: assert property (@(posedge mclk) disable iff (!resetn)
        sel_div && auto_powerup |=> !if_div_q.powerdown ##1 (power_q.if_active == ce_q || $changed(ce_q)))
        else $error("IF powerdown not cleared");
    // The device stores illegal values as written, so these watches report a host that breaks the limits.
    a_rf_n_ceiling: assert property (@(posedge mclk) disable iff (!resetn)
        sel_div && rf_ref_q.prescaler_select |-> word[pll_cfg_pkg::RF_N_MSB:pll_cfg_pkg::RF_N_LSB] <= 11'h7fd)
        else $error("RF main divide above the large prescaler limit");
    a_if_n_floor: assert property (@(posedge mclk) disable iff (!resetn)
        sel_if |-> word[pll_cfg_pkg::IF_N_MSB:pll_cfg_pkg::IF_N_LSB] > 19'h00017)
        else $error("IF main divide too small");

    c_div_write: cover property (@(posedge mclk) disable iff (!resetn) sel_div);
    c_ref_large: cover property (@(posedge mclk) disable iff (!resetn) sel_ref && word[22]);
    c_if_write: cover property (@(posedge mclk) disable iff (!resetn) sel_if);
    c_wake_up: cover property (@(posedge mclk) disable iff (!resetn) wake_q && rf_ref_q.powerdown && power_q.rf_active);

endmodule

`default_nettype wire

// ### design/serial_word_rx.sv
`timescale 1ns/1ps
`default_nettype none

module serial_word_rx (
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Three-wire write pins.
    input wire pll_cfg_pkg::serial_pins_t pins,
    // Received word.
    output logic [pll_cfg_pkg::WORD_W-1:0] word_q,
    output logic word_valid_q
);

    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic clk_prev_q;
    logic latch_prev_q;
    logic [pll_cfg_pkg::WORD_W-1:0] shift_q;
    logic [pll_cfg_pkg::WORD_W-1:0] shift_d;
    logic [pll_cfg_pkg::WORD_W-1:0] word_d;
    logic word_valid_d;

    // Pins pass two flops; only the second stage feeds edge detection.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
            clk_prev_q <= 1'b0;
            latch_prev_q <= 1'b0;
        end else begin
            meta_q <= {pins.clk, pins.data, pins.latch};
            sync_q <= meta_q;
            clk_prev_q <= sync_q[2];
            latch_prev_q <= sync_q[0];
        end
    end

    // Bits enter MSB first on serial clock rises; the latch rise hands the word over.
    // The serial clock must stay below half of mclk so that each edge is seen.
    always_comb begin
        shift_d = shift_q;
        word_d = word_q;
        word_valid_d = 1'b0;
        if (sync_q[2] && !clk_prev_q) begin
            shift_d = {shift_q[pll_cfg_pkg::WORD_W-2:0], sync_q[1]};
        end
        if (sync_q[0] && !latch_prev_q) begin
            word_d = shift_q;
            word_valid_d = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            shift_q <= 24'h000000;
            word_q <= 24'h000000;
            word_valid_q <= 1'b0;
        end else begin
            shift_q <= shift_d;
            word_q <= word_d;
            word_valid_q <= word_valid_d;
        end
    end

endmodule

`default_nettype wire

// ### inc/pll_cfg_pkg.sv
package pll_cfg_pkg;

    // Serial word layout: data in the upper bits, routing code in the low nibble; a divide word is coded by bit 0 low alone, with data down to bit 1.
    localparam int WORD_W = 24;
    localparam int SEL_W = 4;
    localparam int SYNC_STAGES = 2;
    localparam logic [SEL_W-1:0] SEL_RF_REF = 4'h3;
    localparam logic [SEL_W-1:0] SEL_IF_DIV = 4'h5;

    // Divide word fields.
    localparam int RF_N_MSB = 23;
    localparam int RF_N_LSB = 13;
    localparam int RF_FN_MSB = 12;
    localparam int RF_FN_LSB = 1;

    // RF reference word fields.
    localparam int PD_BIT = 23;
    localparam int PSEL_BIT = 22;
    localparam int RREF_MSB = 21;
    localparam int RREF_LSB = 16;
    localparam int FD_MSB = 15;
    localparam int FD_LSB = 4;

    // IF divide word fields.
    localparam int IF_N_MSB = 22;
    localparam int IF_N_LSB = 4;

    // Split of the RF main divide into coarse, mid and fine counts.
    localparam int COARSE_LSB = 5;
    localparam int MID_LSB = 2;
    localparam logic [2:0] MID_WEIGHT_SHIFT = 3'h2;

    // Prescaler moduli selected by rf_prescaler_select.
    localparam logic [5:0] PRESC_SMALL = 6'h10;
    localparam logic [5:0] PRESC_LARGE = 6'h20;

    typedef struct packed {
        logic clk;
        logic data;
        logic latch;
    } serial_pins_t;

    typedef struct packed {
        logic [10:0] main_divide;
        logic [11:0] frac_num;
    } rf_divide_t;

    typedef struct packed {
        logic powerdown;
        logic prescaler_select;
        logic [5:0] reference_divide;
        logic [11:0] frac_den;
    } rf_ref_t;

    typedef struct packed {
        logic powerdown;
        logic [18:0] main_divide;
    } if_div_t;

    typedef struct packed {
        logic rf_active;
        logic rf_cp_hiz;
        logic if_active;
        logic if_cp_hiz;
    } power_t;

    // Values after reset: both synthesizers held down until configured.
    localparam rf_divide_t RST_RF_DIV = '{main_divide: 11'h000, frac_num: 12'h000};
    localparam rf_ref_t RST_RF_REF = '{powerdown: 1'b1, prescaler_select: 1'b0,
                                       reference_divide: 6'h01, frac_den: 12'h000};
    localparam if_div_t RST_IF_DIV = '{powerdown: 1'b1, main_divide: 19'h00000};
    localparam power_t RST_POWER = '{rf_active: 1'b0, rf_cp_hiz: 1'b1, if_active: 1'b0, if_cp_hiz: 1'b1};

endpackage

// ### verification/host_serial_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_serial_model (
    // Clock.
    input wire logic mclk,
    // Three-wire write pins.
    output var pll_cfg_pkg::serial_pins_t pins
);
    initial pins = '{clk: 1'b0, data: 1'b0, latch: 1'b0};

    // Shifts one word out MSB first, at least three mclk cycles per phase so the sync stages see every level.
    task automatic send_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            @(posedge mclk);
            pins.data <= w[i];
            repeat (3) @(posedge mclk);
            pins.clk <= 1'b1;
            repeat (3) @(posedge mclk);
            pins.clk <= 1'b0;
        end
        // The serial clock stays low while the latch rises, so no stray bit gets shifted.
        repeat (3) @(posedge mclk);
        pins.latch <= 1'b1;
        repeat (3) @(posedge mclk);
        pins.latch <= 1'b0;
        // The data line is undriven between words; show the inverse of the last bit.
        pins.data <= ~w[0];
    endtask
endmodule

`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic mclk = 1'b0;
    logic resetn;
    logic chip_enable_pin;
    logic auto_powerup;
    pll_cfg_pkg::serial_pins_t serial_pins;
    pll_cfg_pkg::rf_divide_t rf_divide_q;
    pll_cfg_pkg::rf_ref_t rf_ref_q;
    pll_cfg_pkg::if_div_t if_div_q;
    logic [5:0] rf_coarse_count_q;
    logic [2:0] rf_mid_count_q;
    logic [1:0] rf_fine_count_q;
    logic [11:0] rf_divide_ratio_q;
    pll_cfg_pkg::power_t power_q;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;

    host_serial_model i_host (.mclk(mclk), .pins(serial_pins));

    pll_divider_config i_dut (.mclk(mclk), .resetn(resetn), .serial_pins(serial_pins),
        .chip_enable_pin(chip_enable_pin), .auto_powerup(auto_powerup), .rf_divide_q(rf_divide_q),
        .rf_ref_q(rf_ref_q), .if_div_q(if_div_q), .rf_coarse_count_q(rf_coarse_count_q),
        .rf_mid_count_q(rf_mid_count_q), .rf_fine_count_q(rf_fine_count_q),
        .rf_divide_ratio_q(rf_divide_ratio_q), .power_q(power_q));

    // Half period of 10 ns gives the 50 MHz clock.
    always #10 mclk = ~mclk;

    // A hung handshake would stall the run; the ceiling is far above the ~2600 cycles needed.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("Comparisons: %0d, mismatches: %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Sampling 1 ns after the edge lets that edge's register updates land first.
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [23:0] w);
        i_host.send_word(w);
        settle(6);
    endtask

    function automatic logic [11:0] exp_ratio(input logic psel, input logic [10:0] n);
        return (psel ? 12'h020 : 12'h010) * n[10:5] + 12'h004 * n[4:2] + n[1:0];
    endfunction

    task automatic t_reset();
        chk(rf_divide_q, 24'h000000);
        chk(rf_ref_q, {1'b1, 1'b0, 6'h01, 12'h000});
        chk(if_div_q, {1'b1, 19'h00000});
        chk(power_q, 4'h5);
    endtask

    // Reference divide at both ends of its range, with each prescaler setting.
    task automatic t_ref_fields();
        wr({1'b1, 1'b0, 6'h01, 12'habc, 4'h3});
        chk(rf_ref_q, {1'b1, 1'b0, 6'h01, 12'habc});
        wr({1'b1, 1'b1, 6'h3f, 12'h123, 4'h3});
        chk(rf_ref_q, {1'b1, 1'b1, 6'h3f, 12'h123});
    endtask

    // Legal large-prescaler values; then the small prescaler changes the modulus.
    task automatic t_divide_ratio();
        logic [10:0] vals[3] = '{11'd103, 11'd211, 11'd2045};
        foreach (vals[k]) begin
            wr({vals[k], 12'h5a5, 1'b0});
            chk(rf_divide_q, {vals[k], 12'h5a5});
            chk({rf_coarse_count_q, rf_mid_count_q, rf_fine_count_q}, vals[k]);
            chk(rf_divide_ratio_q, exp_ratio(1'b1, vals[k]));
        end
        wr({1'b1, 1'b0, 6'h3f, 12'h123, 4'h3});
        chk(rf_divide_ratio_q, exp_ratio(1'b0, 11'd2045));
    endtask

    // Reserved codes leave all three registers alone; IF words land on code 0101.
    task automatic t_routing();
        logic [3:0] codes[3] = '{4'h7, 4'h9, 4'hf};
        logic [19:0] ref_was;
        logic [22:0] div_was;
        ref_was = rf_ref_q;
        div_was = rf_divide_q;
        foreach (codes[k]) begin
            wr({20'h0f0f0, codes[k]});
            chk(rf_ref_q, ref_was);
            chk(rf_divide_q, div_was);
            chk(if_div_q, {1'b1, 19'h00000});
        end
        wr({1'b1, 19'd24, 4'h5});
        chk(if_div_q, {1'b1, 19'd24});
        wr({1'b1, 19'd54, 4'h5});
        chk(if_div_q, {1'b1, 19'd54});
    endtask

    task automatic set_pins(input logic ce, input logic auto);
        @(posedge mclk);
        chip_enable_pin <= ce;
        auto_powerup <= auto;
        settle(5);
    endtask

    // Power precedence: pin first, then the wake request, then the register bits.
    task automatic t_power();
        wr({1'b0, 1'b1, 6'h01, 12'h001, 4'h3});
        chk(power_q, 4'h9);
        set_pins(1'b0, 1'b0);
        chk(power_q, 4'h5);
        set_pins(1'b1, 1'b0);
        wr({1'b1, 1'b1, 6'h01, 12'h001, 4'h3});
        chk(power_q, 4'h5);
        set_pins(1'b1, 1'b1);
        wr({11'd103, 12'h000, 1'b0});
        chk(if_div_q, {1'b0, 19'd54});
        chk(power_q, 4'ha);
        set_pins(1'b0, 1'b1);
        chk(power_q, 4'h5);
        set_pins(1'b1, 1'b0);
        chk(power_q, 4'h6);
    endtask

    initial begin
        resetn = 1'b0;
        chip_enable_pin = 1'b1;
        auto_powerup = 1'b0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        settle(3);
        t_reset();
        t_ref_fields();
        t_divide_ratio();
        t_routing();
        t_power();
        finish_test();
    end
endmodule

`default_nettype wire
